/* adcp_consts.svh */
`ifndef ADCP_CONSTS_SVH
`define ADCP_CONSTS_SVH

// ********************************
// Widths and fixed counts
// ********************************
`define ADCP_DATA_W 8
`define ADCP_AIN_W 10
`define ADCP_AIN_FS 1024
`define ADCP_NCHAN 8
`define ADCP_CNT_W 16
`define ADCP_CONV_PERIODS 2184
`define ADCP_PH0_DEF 16
`define ADCP_CONV_DIV_DEF 125

// ********************************
// Command codes and transfer curve
// ********************************
`define ADCP_ENABLE_CODE 5'h19
`define ADCP_LAST_CHAN 3'h7
`define ADCP_LO_PCT 15
`define ADCP_HI_PCT 85
`define ADCP_PCT_SCALE 100
`define ADCP_FULL_CODE 255
`define ADCP_RST_RESULT 8'h00

// ********************************
// Register port
// ********************************
`define ADCP_REG_AW 5
`define ADCP_REG_DW 32
`define ADCP_REG_STATUS 5'h00
`define ADCP_REG_RESULT 5'h04
`define ADCP_REG_IRQ_STAT 5'h08
`define ADCP_REG_IRQ_CLR 5'h0c
`define ADCP_REG_IRQ_EN 5'h10
`define ADCP_IRQ_W 3
`define ADCP_IRQ_DONE 0
`define ADCP_IRQ_OVERRUN 1
`define ADCP_IRQ_STANDBY 2

`endif

/* adcp_pkg.sv */
`include "adcp_consts.svh"

package adcp_pkg;

  // Conversion sequencer phases
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_RESET = 2'b01,
    PH_INTEG = 2'b10
  } adcp_phase_e;

  // Host control pins, sampled together
  typedef struct packed {
    logic enableDecodeStrobe;
    logic enableDecodeQualifier;
    logic transferStrobe;
    logic dirSelect;
  } adcp_host_s;

  // One digitised level per analog channel, in 1/1024 of reference
  typedef logic [`ADCP_NCHAN-1:0][`ADCP_AIN_W-1:0] adcp_ain_t;

endpackage

/* adcp_conv_core.sv */
`timescale 1ns/1ps
`include "adcp_consts.svh"

module adcp_conv_core #(
  parameter int PH0_PERIODS = `ADCP_PH0_DEF,
  parameter int CONV_PERIODS = `ADCP_CONV_PERIODS
) (
  input wire logic core_clk, // System clock
  input wire logic arst_n, // Async reset, low
  input wire logic tick, // Conversion clock enable
  input wire logic start, // Accepted convert start
  input wire logic [`ADCP_AIN_W-1:0] sample, // Selected channel level
  output logic done, // Result valid pulse
  output logic [`ADCP_DATA_W-1:0] result // Converted byte
);

  localparam logic [`ADCP_CNT_W-1:0] PH0_LAST = `ADCP_CNT_W'(PH0_PERIODS - 1);
  localparam logic [`ADCP_CNT_W-1:0] CONV_LAST = `ADCP_CNT_W'(CONV_PERIODS - 1);

  if (PH0_PERIODS < 1 || CONV_PERIODS < 1 || CONV_PERIODS >= 2 ** `ADCP_CNT_W) begin : g_bad
    $error("adcp_conv_core: phase lengths out of range");
  end

  adcp_pkg::adcp_phase_e phaseQ;
  logic [`ADCP_CNT_W-1:0] cntQ;
  logic [`ADCP_AIN_W-1:0] sampleQ;

  // Clamped linear transfer between the two range limits
  function automatic logic [`ADCP_DATA_W-1:0] quantize(input logic [`ADCP_AIN_W-1:0] x);
    int scaled;
    scaled = int'(x) * `ADCP_PCT_SCALE;
    if (scaled <= `ADCP_LO_PCT * `ADCP_AIN_FS) begin
      quantize = '0;
    end else if (scaled >= `ADCP_HI_PCT * `ADCP_AIN_FS) begin
      quantize = `ADCP_DATA_W'(`ADCP_FULL_CODE);
    end else begin
      quantize = `ADCP_DATA_W'((scaled - `ADCP_LO_PCT * `ADCP_AIN_FS) * `ADCP_FULL_CODE
        / ((`ADCP_HI_PCT - `ADCP_LO_PCT) * `ADCP_AIN_FS));
    end
  endfunction

  // Phase sequencer; a restart always wins over the running count
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      phaseQ <= adcp_pkg::PH_IDLE;
      cntQ <= '0;
      sampleQ <= '0;
    end else if (start) begin
      phaseQ <= adcp_pkg::PH_RESET;
      cntQ <= '0;
      sampleQ <= sample;
    end else if (tick) begin
      case (phaseQ)
        adcp_pkg::PH_RESET: begin
          if (cntQ == PH0_LAST) begin
            phaseQ <= adcp_pkg::PH_INTEG;
            cntQ <= '0;
          end else begin
            cntQ <= cntQ + 1'b1;
          end
        end
        adcp_pkg::PH_INTEG: begin
          if (cntQ == CONV_LAST) begin
            phaseQ <= adcp_pkg::PH_IDLE;
          end else begin
            cntQ <= cntQ + 1'b1;
          end
        end
        default: begin
          phaseQ <= adcp_pkg::PH_IDLE;
        end
      endcase
    end
  end

  // Result and completion pulse
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      done <= 1'b0;
      result <= `ADCP_RST_RESULT;
    end else begin
      done <= !start && tick && phaseQ == adcp_pkg::PH_INTEG && cntQ == CONV_LAST;
      if (!start && tick && phaseQ == adcp_pkg::PH_INTEG && cntQ == CONV_LAST) begin
        result <= quantize(sampleQ);
      end
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  a_clamp_low: assert property (done && int'(sampleQ) * `ADCP_PCT_SCALE <= `ADCP_LO_PCT * `ADCP_AIN_FS
    |-> result == '0) else $error("low input not clamped to zero");
  a_clamp_high: assert property (done && int'(sampleQ) * `ADCP_PCT_SCALE >= `ADCP_HI_PCT * `ADCP_AIN_FS
    |-> result == `ADCP_DATA_W'(`ADCP_FULL_CODE)) else $error("high input not clamped");

endmodule

/* adcp_host_port.sv */
`timescale 1ns/1ps
`include "adcp_consts.svh"

module adcp_host_port #(
  parameter int CONV_DIV = `ADCP_CONV_DIV_DEF,
  parameter int PH0_PERIODS = `ADCP_PH0_DEF,
  parameter int CONV_PERIODS = `ADCP_CONV_PERIODS
) (
  input wire logic core_clk, // System clock, 125 MHz
  input wire logic arst_n, // Async reset, low
  input wire adcp_pkg::adcp_host_s hostCtl, // Host control pins
  input wire logic [`ADCP_DATA_W-1:0] dataIn, // Bus level seen
  output logic [`ADCP_DATA_W-1:0] dataOut, // Bus drive value
  output logic dataOe, // Bus driven while high
  output logic busyN, // Low while converting
  output logic [3:0] auxLatchOutputs, // Aux latch bits
  output logic [2:0] channelSelect, // Selected analog channel
  input wire adcp_pkg::adcp_ain_t analogChannelInput, // Channel levels
  input wire logic [`ADCP_REG_AW-1:0] regAddr, // Register address
  input wire logic [`ADCP_REG_DW-1:0] regWrData, // Register write data
  input wire logic regWr, // Write strobe
  input wire logic regRd, // Read strobe
  output logic [`ADCP_REG_DW-1:0] regRdData, // Read data, next cycle
  output logic irq // Level interrupt
);

  // ********************************
  // Parameters and checks
  // ********************************
  localparam int NSTB = 2;
  localparam int DEC = 0;
  localparam int XFR = 1;
  localparam logic [`ADCP_CNT_W-1:0] DIV_LAST = `ADCP_CNT_W'(CONV_DIV - 1);
  // One conversion clock of strobe width, counted in core cycles
  localparam logic [`ADCP_CNT_W-1:0] STB_LAST = `ADCP_CNT_W'(CONV_DIV - 1);

  // A one-cycle divider would let the done pulse and a tick collide
  if (CONV_DIV < 2 || CONV_DIV >= 2 ** `ADCP_CNT_W) begin : g_bad_div
    $error("adcp_host_port: CONV_DIV out of range");
  end

  // ********************************
  // Conversion clock divider
  // ********************************
  logic [`ADCP_CNT_W-1:0] divCntQ;
  logic tickQ;

  // Free-running, so phase zero starts within one period of a start
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      divCntQ <= '0;
      tickQ <= 1'b0;
    end else if (divCntQ == DIV_LAST) begin
      divCntQ <= '0;
      tickQ <= 1'b1;
    end else begin
      divCntQ <= divCntQ + 1'b1;
      tickQ <= 1'b0;
    end
  end

  // ********************************
  // Strobe qualification
  // ********************************
  logic [NSTB-1:0] stbLevel;
  logic [NSTB-1:0] stbCtl;
  logic [NSTB-1:0] stbFire;
  logic [NSTB-1:0] stbHeld;
  logic [NSTB-1:0][`ADCP_DATA_W-1:0] stbData;
  logic [NSTB-1:0] stbCtlAtRise;

  assign stbLevel = {hostCtl.transferStrobe, hostCtl.enableDecodeStrobe};
  assign stbCtl = {hostCtl.dirSelect, hostCtl.enableDecodeQualifier};

  // Both strobes share one shape: capture at the rising edge, act once wide enough
  for (genvar i = 0; i < NSTB; i++) begin : g_stb
    logic [`ADCP_CNT_W-1:0] cntQ;
    logic [`ADCP_DATA_W-1:0] capQ;
    logic ctlQ;

    always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
        cntQ <= '0;
      end else if (!stbLevel[i]) begin
        cntQ <= '0;
      end else if (cntQ <= STB_LAST) begin
        cntQ <= cntQ + 1'b1;
      end
    end

    // Bus and mode are held from the rising edge, as an edge latch would
    always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
        capQ <= '0;
        ctlQ <= 1'b0;
      end else if (stbLevel[i] && cntQ == '0) begin
        capQ <= dataIn;
        ctlQ <= stbCtl[i];
      end
    end

    assign stbFire[i] = stbLevel[i] && cntQ == STB_LAST;
    assign stbHeld[i] = stbLevel[i] && cntQ >= STB_LAST;
    assign stbData[i] = (cntQ == '0) ? dataIn : capQ;
    assign stbCtlAtRise[i] = (cntQ == '0) ? stbCtl[i] : ctlQ;
  end

  // ********************************
  // Command decode
  // ********************************
  logic enabledQ;
  logic codeOk;
  logic startAccept;
  logic readLevel;
  logic standbyEvt;

  // Channel address decode, bit 3 forces the last channel
  function automatic logic [2:0] chanDecode(input logic [3:0] addr);
    chanDecode = addr[3] ? `ADCP_LAST_CHAN : addr[2:0];
  endfunction

  assign codeOk = stbCtlAtRise[DEC] && stbData[DEC][4:0] == `ADCP_ENABLE_CODE;
  assign standbyEvt = stbFire[DEC] && !codeOk;
  assign startAccept = stbFire[XFR] && stbCtlAtRise[XFR] && enabledQ;
  assign readLevel = enabledQ && stbHeld[XFR] && !hostCtl.dirSelect;

  // Enable latch; standby on any other decode, reset also clears it
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      enabledQ <= 1'b0;
    end else if (stbFire[DEC]) begin
      enabledQ <= codeOk;
    end
  end

  // ********************************
  // Conversion control
  // ********************************
  logic coreDone;
  logic [`ADCP_DATA_W-1:0] coreResult;
  logic [`ADCP_DATA_W-1:0] resultQ;

  adcp_conv_core #(
    .PH0_PERIODS(PH0_PERIODS),
    .CONV_PERIODS(CONV_PERIODS)
  ) u_core (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .tick(tickQ),
    .start(startAccept),
    .sample(analogChannelInput[chanDecode(stbData[XFR][3:0])]),
    .done(coreDone),
    .result(coreResult)
  );

  // Address and aux bits latched by every accepted start
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      auxLatchOutputs <= '0;
      channelSelect <= '0;
    end else if (startAccept) begin
      auxLatchOutputs <= stbData[XFR][7:4];
      channelSelect <= chanDecode(stbData[XFR][3:0]);
    end
  end

  // Busy: a new start outranks a completion landing in the same cycle
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      busyN <= 1'b1;
    end else if (startAccept) begin
      busyN <= 1'b0;
    end else if (coreDone) begin
      busyN <= 1'b1;
    end
  end

  // Result holding register, only a completion changes it
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      resultQ <= `ADCP_RST_RESULT;
    end else if (coreDone && !startAccept) begin
      resultQ <= coreResult;
    end
  end

  // ********************************
  // Data bus drivers
  // ********************************
  // Drivers follow the strobe level; release costs one cycle after low
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      dataOe <= 1'b0;
      dataOut <= '0;
    end else begin
      dataOe <= readLevel;
      dataOut <= readLevel ? resultQ : '0;
    end
  end

  // ********************************
  // Register port and interrupts
  // ********************************
  logic [`ADCP_IRQ_W-1:0] irqStatQ;
  logic [`ADCP_IRQ_W-1:0] irqEnQ;
  logic [`ADCP_IRQ_W-1:0] irqEvt;
  logic [`ADCP_IRQ_W-1:0] irqClr;

  assign irqEvt[`ADCP_IRQ_DONE] = coreDone && !startAccept;
  assign irqEvt[`ADCP_IRQ_OVERRUN] = startAccept && !busyN;
  assign irqEvt[`ADCP_IRQ_STANDBY] = standbyEvt;
  assign irqClr = (regWr && regAddr == `ADCP_REG_IRQ_CLR) ? regWrData[`ADCP_IRQ_W-1:0] : '0;

  // Sticky status; a new event beats a clear in the same cycle
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      irqStatQ <= '0;
    end else begin
      irqStatQ <= (irqStatQ & ~irqClr) | irqEvt;
    end
  end

  // Enable mask
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      irqEnQ <= '0;
    end else if (regWr && regAddr == `ADCP_REG_IRQ_EN) begin
      irqEnQ <= regWrData[`ADCP_IRQ_W-1:0];
    end
  end

  // Interrupt level, one cycle behind the status
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irqStatQ & irqEnQ);
    end
  end

  // Read mux; unmapped and write-only addresses read zero
  function automatic logic [`ADCP_REG_DW-1:0] regRead(input logic [`ADCP_REG_AW-1:0] a);
    regRead = '0;
    case (a)
      `ADCP_REG_STATUS: begin
        regRead[0] = enabledQ;
        regRead[1] = !busyN;
        regRead[6:4] = channelSelect;
        regRead[11:8] = auxLatchOutputs;
      end
      `ADCP_REG_RESULT: regRead[`ADCP_DATA_W-1:0] = resultQ;
      `ADCP_REG_IRQ_STAT: regRead[`ADCP_IRQ_W-1:0] = irqStatQ;
      `ADCP_REG_IRQ_EN: regRead[`ADCP_IRQ_W-1:0] = irqEnQ;
      default: regRead = '0;
    endcase
  endfunction

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      regRdData <= '0;
    end else begin
      regRdData <= regRd ? regRead(regAddr) : '0;
    end
  end

  // ********************************
  // Checks
  // ********************************
  localparam int CONV_TOTAL = PH0_PERIODS + CONV_PERIODS;
  logic [`ADCP_CNT_W-1:0] chkTicksQ;

  // Conversion clocks seen while busy, for the length check
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      chkTicksQ <= '0;
    end else if (startAccept) begin
      chkTicksQ <= '0;
    end else if (tickQ && !busyN) begin
      chkTicksQ <= chkTicksQ + 1'b1;
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  a_conv_length: assert property ($rose(busyN) |-> int'(chkTicksQ) == CONV_TOTAL)
    else $error("conversion length wrong");
  a_busy_start: assert property (startAccept |=> !busyN)
    else $error("busy not low after start");
  a_busy_release: assert property (coreDone && !startAccept |=> busyN && resultQ == $past(coreResult))
    else $error("busy not high with result");
  a_read_drive: assert property (readLevel |=> dataOe && dataOut == $past(resultQ))
    else $error("read did not drive result");
  a_bus_release: assert property (!hostCtl.transferStrobe |=> !dataOe)
    else $error("bus not released");
  a_aux_latch: assert property (startAccept |=> auxLatchOutputs == $past(stbData[XFR][7:4]))
    else $error("aux latch wrong");
  a_chan_select: assert property (startAccept && stbData[XFR][3] |=> channelSelect == `ADCP_LAST_CHAN)
    else $error("bit 3 did not pick last channel");
  a_standby_ignore: assert property (!enabledQ && busyN |=> busyN)
    else $error("start taken in standby");
  a_decode_enable: assert property (stbFire[DEC] |=> enabledQ == $past(codeOk))
    else $error("enable latch wrong");
  a_strobe_width: assert property (startAccept |-> $past(hostCtl.transferStrobe, 1) || CONV_DIV == 1)
    else $error("start taken on a narrow strobe");
  a_result_hold: assert property (busyN && $past(busyN) |-> $stable(resultQ))
    else $error("result changed while idle");
  // Phase zero is entered on the next cycle, well inside one conversion clock
  a_phase_begin: assert property (startAccept |=> u_core.phaseQ == adcp_pkg::PH_RESET && u_core.cntQ == '0)
    else $error("phase zero did not begin");
  // Interrupt path: a clear never hides an event of the same cycle
  a_irq_sticky: assert property (irqEvt[`ADCP_IRQ_DONE] |=> irqStatQ[`ADCP_IRQ_DONE])
    else $error("done event lost");
  a_irq_level: assert property (irq == $past(|(irqStatQ & irqEnQ)))
    else $error("interrupt level wrong");
  a_overrun_flag: assert property (startAccept && !busyN |=> irqStatQ[`ADCP_IRQ_OVERRUN])
    else $error("restart not flagged");

  // Main scenarios the bench must reach
  c_enable: cover property (stbFire[DEC] && codeOk);
  c_convert: cover property ($rose(busyN));
  c_read: cover property (readLevel ##1 !hostCtl.transferStrobe);
  c_overrun: cover property (irqEvt[`ADCP_IRQ_OVERRUN]);
  c_standby: cover property (standbyEvt);

endmodule

/* adcp_host_model.sv */
`timescale 1ns/1ps
`include "adcp_consts.svh"

module adcp_host_model (
  input wire logic core_clk, // System clock
  input wire logic [`ADCP_DATA_W-1:0] dataOut, // Device bus drive
  input wire logic dataOe, // Device drives bus
  output adcp_pkg::adcp_host_s hostCtl, // Host control pins
  output logic [`ADCP_DATA_W-1:0] dataIn // Resolved bus level
);
  // ********************************
  // Shared bus
  // ********************************
  logic [`ADCP_DATA_W-1:0] hostData;
  logic hostOe;
  logic [`ADCP_DATA_W-1:0] lastBus;

  initial begin
    hostCtl = '0;
    hostData = 8'h00;
    hostOe = 1'b0;
    lastBus = 8'h00;
  end

  // Undriven bus flips every cycle so a stale value never looks valid
  always_comb dataIn = dataOe ? dataOut : (hostOe ? hostData : ~lastBus);

  always @(posedge core_clk) lastBus <= dataIn;

  // ********************************
  // One strobed command
  // ********************************
  // Qualifiers and data settle a cycle ahead of the strobe
  task automatic pinCycle(input logic isDecode, input logic qual, input logic dir, input logic drive,
                          input logic [7:0] d, input int width, output logic [7:0] seen);
    @(posedge core_clk);
    hostCtl.enableDecodeQualifier <= qual;
    hostCtl.dirSelect <= dir;
    hostOe <= drive;
    hostData <= d;
    @(posedge core_clk);
    if (isDecode) hostCtl.enableDecodeStrobe <= 1'b1;
    else hostCtl.transferStrobe <= 1'b1;
    repeat (width) @(posedge core_clk);
    seen = dataIn;
    hostCtl.enableDecodeStrobe <= 1'b0;
    hostCtl.transferStrobe <= 1'b0;
    @(posedge core_clk);
    hostOe <= 1'b0;
    hostCtl.enableDecodeQualifier <= 1'b0;
  endtask
endmodule

/* tb_adc_host_command_port.sv */
`timescale 1ns/1ps
`include "adcp_consts.svh"

module tb_adc_host_command_port;
  // ********************************
  // Setup
  // ********************************
  localparam int DIV = 2;
  localparam int PH0 = 2;
  localparam int CONV = `ADCP_CONV_PERIODS;
  // Quickest busy time; tick alignment may add one cycle
  localparam int LO = (PH0 + CONV) * DIV;

  logic core_clk;
  logic arst_n;
  adcp_pkg::adcp_host_s hostCtl;
  logic [`ADCP_DATA_W-1:0] dataIn;
  logic [`ADCP_DATA_W-1:0] dataOut;
  logic dataOe;
  logic busyN;
  logic [3:0] auxLatchOutputs;
  logic [2:0] channelSelect;
  adcp_pkg::adcp_ain_t analogChannelInput;
  logic [`ADCP_REG_AW-1:0] regAddr;
  logic [`ADCP_REG_DW-1:0] regWrData;
  logic regWr;
  logic regRd;
  logic [`ADCP_REG_DW-1:0] regRdData;
  logic irq;
  int num_errors = 0;
  int n_tests = 0;
  int lowCnt = 0;
  int levels [8] = '{0, 153, 512, 1023, 871, 300, 700, 160};
  logic [7:0] cmds [9] = '{8'h50, 8'h31, 8'hf2, 8'h03, 8'ha4, 8'h05, 8'h06, 8'h67, 8'h9b};

  adcp_host_port #(.CONV_DIV(DIV), .PH0_PERIODS(PH0), .CONV_PERIODS(CONV)) dut (
    .core_clk(core_clk), .arst_n(arst_n), .hostCtl(hostCtl), .dataIn(dataIn), .dataOut(dataOut),
    .dataOe(dataOe), .busyN(busyN), .auxLatchOutputs(auxLatchOutputs), .channelSelect(channelSelect),
    .analogChannelInput(analogChannelInput), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd), .regRdData(regRdData), .irq(irq));

  adcp_host_model host (.core_clk(core_clk), .dataOut(dataOut), .dataOe(dataOe), .hostCtl(hostCtl),
    .dataIn(dataIn));

  initial core_clk = 1'b0;
  always #4 core_clk = ~core_clk;

  // Cycles spent converting, cleared before each start in the conversion loop
  always @(posedge core_clk) if (busyN === 1'b0) lowCnt <= lowCnt + 1;

  // ********************************
  // Helpers
  // ********************************
  task automatic stop_test;
    $display("counts: %0d compares, %0d mismatches", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      num_errors++;
    end
  endtask

  task automatic chkIn(input int got, input int lo, input int hi);
    n_tests++;
    if (got < lo || got > hi) begin
      $display("unexpected at %0t: got %h expected %h to %h", $time, got, lo, hi);
      num_errors++;
    end
  endtask

  task automatic regW(input logic [`ADCP_REG_AW-1:0] a, input logic [31:0] d);
    @(posedge core_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask

  task automatic regR(input logic [`ADCP_REG_AW-1:0] a, output logic [31:0] d);
    @(posedge core_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRd <= 1'b0;
    #1 d = regRdData;
  endtask

  // Bounded wait on the busy line; running out ends the run
  task automatic waitBusy(input logic lvl);
    int n;
    n = 0;
    while (busyN !== lvl && n < 6000) begin
      @(posedge core_clk);
      n++;
    end
    if (busyN !== lvl) begin
      num_errors++;
      $display("unexpected at %0t: busy wait ran out, got %h expected %h", $time, busyN, lvl);
      stop_test();
    end
  endtask

  // Clamped straight line between the two limits
  function automatic logic [7:0] expCode(input int x);
    int p;
    p = x * `ADCP_PCT_SCALE;
    if (p <= `ADCP_LO_PCT * `ADCP_AIN_FS) return 8'h00;
    if (p >= `ADCP_HI_PCT * `ADCP_AIN_FS) return 8'hff;
    return 8'((p - `ADCP_LO_PCT * `ADCP_AIN_FS) * `ADCP_FULL_CODE / ((`ADCP_HI_PCT - `ADCP_LO_PCT) * `ADCP_AIN_FS));
  endfunction

  // ********************************
  // Sequence
  // ********************************
  initial begin
    logic [31:0] rd;
    logic [7:0] seen;
    logic [7:0] b;
    logic [7:0] ex;
    arst_n = 1'b0;
    regAddr = '0;
    regWrData = '0;
    regWr = 1'b0;
    regRd = 1'b0;
    for (int k = 0; k < 8; k++) analogChannelInput[k] = 10'(levels[k]);
    repeat (10) @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    chk(busyN, 1'b1);
    chk(dataOe, 1'b0);
    chk({auxLatchOutputs, channelSelect, irq}, 8'h00);
    regR(`ADCP_REG_STATUS, rd);
    chk(rd, 32'h0);
    host.pinCycle(1'b0, 1'b0, 1'b1, 1'b1, 8'h35, DIV + 3, seen);
    repeat (4) @(posedge core_clk);
    chk(busyN, 1'b1);
    $display("test reset and standby start done");

    // Upper bits of the enable code are free
    host.pinCycle(1'b1, 1'b1, 1'b0, 1'b1, 8'hf9, DIV + 3, seen);
    regR(`ADCP_REG_STATUS, rd);
    chk(rd[0], 1'b1);
    for (int i = 0; i < 9; i++) begin
      b = cmds[i];
      ex = expCode(levels[b[3] ? 7 : b[2:0]]);
      waitBusy(1'b1);
      lowCnt = 0;
      host.pinCycle(1'b0, 1'b0, 1'b1, 1'b1, b, DIV + 3, seen);
      chk(busyN, 1'b0);
      chk(channelSelect, b[3] ? 3'h7 : b[2:0]);
      waitBusy(1'b1);
      chkIn(lowCnt, LO, LO + DIV + 3);
      chk(auxLatchOutputs, b[7:4]);
      host.pinCycle(1'b0, 1'b0, 1'b0, 1'b0, 8'h00, DIV + 3, seen);
      chk(seen, ex);
      repeat (3) @(posedge core_clk);
      chk({dataOe, dataOut}, 9'h000);
      regR(`ADCP_REG_RESULT, rd);
      chk(rd, {24'h0, ex});
      regR(`ADCP_REG_IRQ_STAT, rd);
      chk(rd[0], 1'b1);
      chk(irq, i != 0);
      if (i == 0) begin
        regW(`ADCP_REG_IRQ_EN, 32'h1);
        repeat (2) @(posedge core_clk);
        chk(irq, 1'b1);
      end
      regW(`ADCP_REG_IRQ_CLR, 32'h7);
      repeat (2) @(posedge core_clk);
      chk(irq, 1'b0);
    end
    $display("test conversions done");

    // Read-only result and an unmapped place
    regW(`ADCP_REG_RESULT, 32'h5a);
    regR(`ADCP_REG_RESULT, rd);
    chk(rd, {24'h0, ex});
    regR(5'h1c, rd);
    chk(rd, 32'h0);
    // Too short a strobe must not start
    host.pinCycle(1'b0, 1'b0, 1'b1, 1'b1, 8'h02, 1, seen);
    repeat (4) @(posedge core_clk);
    chk(busyN, 1'b1);
    $display("test registers and narrow strobe done");

    // Wrong code, then a low qualifier, each leave the port deaf
    for (int m = 0; m < 2; m++) begin
      host.pinCycle(1'b1, m == 0, 1'b0, 1'b1, m == 0 ? 8'h18 : 8'h19, DIV + 3, seen);
      regR(`ADCP_REG_STATUS, rd);
      chk(rd[0], 1'b0);
      regR(`ADCP_REG_IRQ_STAT, rd);
      chk(rd[2], 1'b1);
      host.pinCycle(1'b0, 1'b0, 1'b1, 1'b1, 8'h01, DIV + 3, seen);
      repeat (4) @(posedge core_clk);
      chk(busyN, 1'b1);
      regW(`ADCP_REG_IRQ_CLR, 32'h7);
      host.pinCycle(1'b1, 1'b1, 1'b0, 1'b1, 8'h19, DIV + 3, seen);
    end
    $display("test disable paths done");

    // A start while busy restarts the conversion and is flagged
    host.pinCycle(1'b0, 1'b0, 1'b1, 1'b1, 8'h03, DIV + 3, seen);
    host.pinCycle(1'b0, 1'b0, 1'b1, 1'b1, 8'hc2, DIV + 3, seen);
    chk(busyN, 1'b0);
    chk(auxLatchOutputs, 4'hc);
    regR(`ADCP_REG_IRQ_STAT, rd);
    chk(rd[1], 1'b1);
    waitBusy(1'b1);
    regR(`ADCP_REG_RESULT, rd);
    chk(rd, {24'h0, expCode(levels[2])});
    // A reset pulse drops the port back to standby; held two edges
    @(posedge core_clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    arst_n <= 1'b1;
    regR(`ADCP_REG_STATUS, rd);
    chk(rd, 32'h0);
    host.pinCycle(1'b0, 1'b0, 1'b1, 1'b1, 8'h01, DIV + 3, seen);
    repeat (4) @(posedge core_clk);
    chk(busyN, 1'b1);
    $display("test restart and reset done");
    stop_test();
  end
endmodule
